// ### src/lcs_pkg.sv
// Package of constants for the first LED channel configuration and sequencer.
// Assumes an 8-bit register port driven by the device's serial control front end.
package lcs_pkg;
	// ********************************************************
	// Register offsets
	// ********************************************************
	localparam logic [7:0] ADDR_CURRENT_RAMP = 8'h47;
	localparam logic [7:0] ADDR_PHASE_ONE    = 8'h48;
	localparam logic [7:0] ADDR_PHASE_TWO    = 8'h49;
	localparam logic [7:0] ADDR_PHASE_THREE  = 8'h4a;
	localparam logic [7:0] ADDR_PHASE_FOUR   = 8'h4b;
	localparam logic [7:0] ADDR_PERIOD       = 8'h4c;
	localparam logic [7:0] ADDR_DUTY         = 8'h4d;
	localparam logic [7:0] ADDR_LIT_TIME     = 8'h4e;

	// ********************************************************
	// Field layout and reset values
	// ********************************************************
	localparam int         RAMP_BIT        = 5;
	localparam logic [7:0] MASK_CURRENT    = 8'h2f;
	localparam logic [7:0] MASK_TIME7      = 8'h7f;
	localparam logic [7:0] MASK_FIVE       = 8'h1f;
	localparam logic [7:0] RESET_VALUE     = 8'h00;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int CLK_HZ          = 50_000_000;
	localparam int TICK_MS         = 64;
	localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
	localparam int DUTY_PERIOD_MS  = 8;
	localparam int DUTY_SLOT_CYCLES = CLK_HZ / 1000 * DUTY_PERIOD_MS / 32;

	// Sequencer states, Gray coded along the phase order
	typedef enum logic [2:0] {
		SEQ_ONE   = 3'h0,
		SEQ_TWO   = 3'h1,
		SEQ_THREE = 3'h3,
		SEQ_FOUR  = 3'h2,
		SEQ_REST  = 3'h6
	} lcs_seq_e;
endpackage

// ### src/lcs_tick.sv
// Divider that produces one-cycle tick pulses every DIV cycles.
// Assumes a single clock and synchronous active high reset.
`timescale 1ns/1ps
module lcs_tick #(
	parameter int DIV = 16
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Tick pulse
	output logic      tick
);
	// Refuse a divide ratio that the wrap compare cannot serve
	if (DIV < 2) begin : g_div_check
		$error("lcs_tick: DIV must be at least 2");
	end

	logic [31:0] cnt_r;
	wire         wrap = (cnt_r == 32'(DIV - 1));

	// Free-running count; tick registered so it leaves straight from a flop
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_r <= wrap ? '0 : cnt_r + 32'h1;
			tick  <= wrap;
		end
	end
endmodule

// ### src/lcs_channel.sv
// First LED channel: configuration registers, phase sequencer and duty output.
// Assumes a register port decoded by the serial control interface, one cycle wide.
`timescale 1ns/1ps
module lcs_channel #(
	parameter int TICK_CYCLES = lcs_pkg::TICK_CYCLES,
	parameter int SLOT_CYCLES = lcs_pkg::DUTY_SLOT_CYCLES
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Settings to the current sink
	output logic      [3:0] first_led_sink_level,
	output logic            first_led_ramp_on,
	// Sequencer status and drive
	output logic      [2:0] seq_phase,
	output logic            first_led_drive_signal
);
	// Refuse dividers that the tick counters cannot serve
	if (TICK_CYCLES < 2 || SLOT_CYCLES < 2) begin : g_div_check
		$error("lcs_channel: divider too small");
	end

	// ********************************************************
	// Register file
	// ********************************************************
	logic [7:0] ctl_r, t1_r, t2_r, t3_r, t4_r, tp_r, duty_r, lit_r;

	// Mask per address; zero means unmapped
	function automatic logic [7:0] wmask(input logic [7:0] a);
		if (a == lcs_pkg::ADDR_CURRENT_RAMP) return lcs_pkg::MASK_CURRENT;
		else if (a >= lcs_pkg::ADDR_PHASE_ONE && a <= lcs_pkg::ADDR_PERIOD)
			return lcs_pkg::MASK_TIME7;
		else if (a == lcs_pkg::ADDR_DUTY || a == lcs_pkg::ADDR_LIT_TIME)
			return lcs_pkg::MASK_FIVE;
		else return 8'h00;
	endfunction

	wire [7:0] wdat_m = reg_wdata & wmask(reg_addr);
	wire       wr_ctl = reg_wr && reg_addr == lcs_pkg::ADDR_CURRENT_RAMP;
	wire       wr_t1  = reg_wr && reg_addr == lcs_pkg::ADDR_PHASE_ONE;
	wire       wr_t2  = reg_wr && reg_addr == lcs_pkg::ADDR_PHASE_TWO;
	wire       wr_t3  = reg_wr && reg_addr == lcs_pkg::ADDR_PHASE_THREE;
	wire       wr_t4  = reg_wr && reg_addr == lcs_pkg::ADDR_PHASE_FOUR;
	wire       wr_tp  = reg_wr && reg_addr == lcs_pkg::ADDR_PERIOD;
	wire       wr_dt  = reg_wr && reg_addr == lcs_pkg::ADDR_DUTY;
	wire       wr_lt  = reg_wr && reg_addr == lcs_pkg::ADDR_LIT_TIME;

	// Stored bits are pre-masked, so reserved bits stay zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctl_r  <= lcs_pkg::RESET_VALUE;
			t1_r   <= lcs_pkg::RESET_VALUE;
			t2_r   <= lcs_pkg::RESET_VALUE;
			t3_r   <= lcs_pkg::RESET_VALUE;
			t4_r   <= lcs_pkg::RESET_VALUE;
			tp_r   <= lcs_pkg::RESET_VALUE;
			duty_r <= lcs_pkg::RESET_VALUE;
			lit_r  <= lcs_pkg::RESET_VALUE;
		end else begin
			if (wr_ctl) ctl_r  <= wdat_m;
			if (wr_t1)  t1_r   <= wdat_m;
			if (wr_t2)  t2_r   <= wdat_m;
			if (wr_t3)  t3_r   <= wdat_m;
			if (wr_t4)  t4_r   <= wdat_m;
			if (wr_tp)  tp_r   <= wdat_m;
			if (wr_dt)  duty_r <= wdat_m;
			if (wr_lt)  lit_r  <= wdat_m;
		end
	end

	// Read mux; unmapped addresses answer zero
	wire [7:0] rd_mux =
		(reg_addr == lcs_pkg::ADDR_CURRENT_RAMP) ? ctl_r :
		(reg_addr == lcs_pkg::ADDR_PHASE_ONE)    ? t1_r  :
		(reg_addr == lcs_pkg::ADDR_PHASE_TWO)    ? t2_r  :
		(reg_addr == lcs_pkg::ADDR_PHASE_THREE)  ? t3_r  :
		(reg_addr == lcs_pkg::ADDR_PHASE_FOUR)   ? t4_r  :
		(reg_addr == lcs_pkg::ADDR_PERIOD)       ? tp_r  :
		(reg_addr == lcs_pkg::ADDR_DUTY)         ? duty_r :
		(reg_addr == lcs_pkg::ADDR_LIT_TIME)     ? lit_r : 8'h00;

	// Read data registered one cycle after the strobe and held
	always_ff @(posedge clk) begin
		if (sys_rst) reg_rdata <= 8'h00;
		else if (reg_rd) reg_rdata <= rd_mux & wmask(reg_addr);
	end

	// Settings out, registered copies of the fields
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			first_led_sink_level <= 4'h0;
			first_led_ramp_on    <= 1'b0;
		end else begin
			first_led_sink_level <= ctl_r[3:0];
			first_led_ramp_on    <= ctl_r[lcs_pkg::RAMP_BIT];
		end
	end

	// ********************************************************
	// Time bases
	// ********************************************************
	logic tick_64, tick_slot;

	lcs_tick #(.DIV(TICK_CYCLES)) u_tick64 (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (tick_64)
	);
	lcs_tick #(.DIV(SLOT_CYCLES)) u_slot (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (tick_slot)
	);

	// ********************************************************
	// Phase sequencer
	// ********************************************************
	lcs_pkg::lcs_seq_e st_r, st_nxt;
	logic [6:0]        ph_cnt_r;
	logic [6:0]        per_cnt_r;
	logic [4:0]        lit_cnt_r;

	wire [6:0] ph_len =
		(st_r == lcs_pkg::SEQ_ONE)   ? t1_r[6:0] :
		(st_r == lcs_pkg::SEQ_TWO)   ? t2_r[6:0] :
		(st_r == lcs_pkg::SEQ_THREE) ? t3_r[6:0] :
		(st_r == lcs_pkg::SEQ_FOUR)  ? t4_r[6:0] : 7'h7f;
	// Leave on the tick that completes the phase, so each phase is whole ticks long
	// after a period restart too; a zero length phase still costs one clock
	wire ph_last  = tick_64 && (ph_cnt_r + 7'h1 >= ph_len);
	wire ph_done  = (ph_len == 7'h00) || ph_last;
	wire per_done = tick_64 && (per_cnt_r + 7'h1 >= tp_r[6:0]);

	// Next phase: order one, two, three, four, then rest until the period ends
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			lcs_pkg::SEQ_ONE:   if (ph_done) st_nxt = lcs_pkg::SEQ_TWO;
			lcs_pkg::SEQ_TWO:   if (ph_done) st_nxt = lcs_pkg::SEQ_THREE;
			lcs_pkg::SEQ_THREE: if (ph_done) st_nxt = lcs_pkg::SEQ_FOUR;
			lcs_pkg::SEQ_FOUR:  if (ph_done) st_nxt = lcs_pkg::SEQ_REST;
			default:            st_nxt = lcs_pkg::SEQ_REST;
		endcase
		if (per_done) st_nxt = lcs_pkg::SEQ_ONE;
	end

	// Phase counters advance only on the 64 ms tick
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r      <= lcs_pkg::SEQ_ONE;
			ph_cnt_r  <= 7'h00;
			per_cnt_r <= 7'h00;
		end else begin
			st_r <= st_nxt;
			if (st_nxt != st_r || per_done) ph_cnt_r <= 7'h00;
			else if (tick_64 && ph_cnt_r != 7'h7f) ph_cnt_r <= ph_cnt_r + 7'h1;
			if (per_done) per_cnt_r <= 7'h00;
			else if (tick_64) per_cnt_r <= per_cnt_r + 7'h1;
		end
	end

	// Lit time counts from period start, clamped at its limit
	always_ff @(posedge clk) begin
		if (sys_rst) lit_cnt_r <= 5'h00;
		else if (per_done) lit_cnt_r <= 5'h00;
		else if (tick_64 && lit_cnt_r != 5'h1f) lit_cnt_r <= lit_cnt_r + 5'h1;
	end

	// ********************************************************
	// Duty output
	// ********************************************************
	logic [4:0] slot_r;
	wire        duty_hi = (slot_r <= duty_r[4:0]); // (value+1) slots of 32
	wire        lit_win = (lit_cnt_r < lit_r[4:0]);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slot_r                 <= 5'h00;
			seq_phase              <= 3'h0;
			first_led_drive_signal <= 1'b0;
		end else begin
			if (tick_slot) slot_r <= slot_r + 5'h1; // 32 slots wrap in 8 ms
			seq_phase              <= st_r;
			first_led_drive_signal <= duty_hi && lit_win;
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	property p_reserved_bit_zero;
		@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == lcs_pkg::ADDR_CURRENT_RAMP |=> reg_rdata[7:6] == 2'b00 && !reg_rdata[4];
	endproperty
	a_reserved_bit_zero: assert property (p_reserved_bit_zero) else $error("reserved bit read nonzero");

	property p_ramp;
		@(posedge clk) disable iff (sys_rst)
		wr_ctl |=> ##1 first_led_ramp_on == $past(reg_wdata[5], 2);
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp bit not applied");

	property p_level;
		@(posedge clk) disable iff (sys_rst)
		wr_ctl |=> ##1 first_led_sink_level == $past(reg_wdata[3:0], 2);
	endproperty
	a_level: assert property (p_level) else $error("current code not applied");

	property p_t1_store;
		@(posedge clk) disable iff (sys_rst)
		wr_t1 |=> t1_r == {1'b0, $past(reg_wdata[6:0])};
	endproperty
	a_t1_store: assert property (p_t1_store) else $error("phase one length wrong");

	property p_tp_store;
		@(posedge clk) disable iff (sys_rst)
		wr_tp |=> tp_r == {1'b0, $past(reg_wdata[6:0])};
	endproperty
	a_tp_store: assert property (p_tp_store) else $error("period length wrong");

	property p_reset;
		@(posedge clk) sys_rst |=> ctl_r == 8'h00 && t1_r == 8'h00 && reg_rdata == 8'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("reset value nonzero");

	property p_readback;
		@(posedge clk) disable iff (sys_rst)
		reg_rd && !reg_wr && reg_addr == lcs_pkg::ADDR_PHASE_TWO |=> reg_rdata == t2_r;
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

	property p_order;
		@(posedge clk) disable iff (sys_rst)
		st_r == lcs_pkg::SEQ_ONE && !per_done && st_nxt != st_r |-> st_nxt == lcs_pkg::SEQ_TWO;
	endproperty
	a_order: assert property (p_order) else $error("phase order broken");

	property p_full_duty;
		@(posedge clk) disable iff (sys_rst)
		duty_r[4:0] == 5'h1f && lit_win |=> first_led_drive_signal;
	endproperty
	a_full_duty: assert property (p_full_duty) else $error("full duty not high");

	property p_lit_zero;
		@(posedge clk) disable iff (sys_rst)
		lit_r[4:0] == 5'h00 |=> !first_led_drive_signal;
	endproperty
	a_lit_zero: assert property (p_lit_zero) else $error("zero lit time drove");
endmodule

// ### tb/tb_lcs_channel.sv
// Self-checking bench for the first LED channel register set and sequencer.
// Assumes lcs_channel and lcs_pkg are compiled first; sim-sized tick and slot counts.
`timescale 1ns/1ps
module tb_lcs_channel;
	localparam int TK = 8;
	localparam int SLOT = 4;
	logic       clk;
	logic       sys_rst;
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic [7:0] reg_wdata;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic [3:0] first_led_sink_level;
	logic       first_led_ramp_on;
	logic [2:0] seq_phase;
	logic       first_led_drive_signal;
	int         fail_count;
	int         n_checks;
	logic [7:0] shadow [0:255];
	logic [7:0] rd_val;
	logic [2:0] prev_phase;
	int         ph_cnt;
	int         per_cnt;
	bit         mon_en;
	bit         armed;
	logic [4:0] duty_code;
	int         hi_cnt;

	// Short counts keep each 64 ms tick to a few cycles
	lcs_channel #(.TICK_CYCLES(TK), .SLOT_CYCLES(SLOT)) dut (
		.clk                    (clk),
		.sys_rst                (sys_rst),
		.reg_addr               (reg_addr),
		.reg_wr                 (reg_wr),
		.reg_wdata              (reg_wdata),
		.reg_rd                 (reg_rd),
		.reg_rdata              (reg_rdata),
		.first_led_sink_level   (first_led_sink_level),
		.first_led_ramp_on      (first_led_ramp_on),
		.seq_phase              (seq_phase),
		.first_led_drive_signal (first_led_drive_signal)
	);

	always #10 clk = ~clk;

	// ********************************************************
	// Expectations and helpers
	// ********************************************************
	// Writable bits of each address; anything else reads as zero
	function automatic logic [7:0] wmask(input logic [7:0] a);
		case (a)
			8'h47: return 8'h2f;
			8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c: return 8'h7f;
			8'h4d, 8'h4e: return 8'h1f;
			default: return 8'h00;
		endcase
	endfunction

	// Phase lengths in ticks as programmed in the sequencer scenario
	function automatic int plen(input logic [2:0] p);
		case (p)
			3'h0: return 2;
			3'h1: return 3;
			3'h3: return 1;
			default: return 2;
		endcase
	endfunction

	// High cycles in one full round of 32 slots: (code + 1) slots of SLOT cycles
	function automatic int duty_cycles(input logic [4:0] d);
		return (int'(d) + 1) * SLOT;
	endfunction

	// Successor of a phase code in play order
	function automatic logic [2:0] pnext(input logic [2:0] p);
		case (p)
			3'h0: return 3'h1;
			3'h1: return 3'h3;
			3'h3: return 3'h2;
			3'h2: return 3'h6;
			default: return 3'h0;
		endcase
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
		shadow[a] = d & wmask(a);
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(posedge clk);
		#1 rd_val = reg_rdata;
	endtask

	// Reset, then every mapped register and both settings must be zero
	task automatic reset_check();
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		#1 chk({5'h0, seq_phase}, 8'h00);
		chk({7'h0, first_led_drive_signal}, 8'h00);
		for (int a = 8'h46; a <= 8'h4f; a++) begin
			shadow[a] = 8'h00;
			rd(8'(a));
			chk(rd_val, 8'h00);
		end
		chk({3'h0, first_led_ramp_on, first_led_sink_level}, 8'h00);
	endtask

	task automatic print_verdict();
		if (fail_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ********************************************************
	// Sequencer monitor, sampled on the falling edge to avoid races
	// ********************************************************
	always @(negedge clk) begin
		if (mon_en && seq_phase !== prev_phase) begin
			chk({5'h0, seq_phase}, {5'h0, pnext(prev_phase)});
			if (armed && prev_phase !== 3'h6)
				chk(8'(ph_cnt), 8'(plen(prev_phase) * TK));
			if (armed && seq_phase === 3'h0)
				chk(8'(per_cnt), 8'(12 * TK));
			if (seq_phase === 3'h0) begin
				armed = 1'b1;
				per_cnt = 0;
			end
			ph_cnt = 0;
		end
		ph_cnt++;
		per_cnt++;
		prev_phase = seq_phase;
	end

	// Watchdog sized well above the whole test sequence
	initial begin
		#(20 * 30000);
		fail_count++;
		print_verdict();
	end

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
		fail_count = 0;
		n_checks = 0;
		mon_en = 1'b0;
		armed = 1'b0;
		void'($urandom(32'h7d92b150));
		reset_check();
		// Random writes across mapped and unmapped places, read back masked
		for (int i = 0; i < 40; i++) begin
			logic [7:0] a;
			a = 8'h44 + 8'($urandom % 12);
			wr(a, 8'($urandom));
			if (a == 8'h47) begin
				@(posedge clk);
				#1 chk({4'h0, first_led_sink_level}, {4'h0, shadow[a][3:0]});
				chk({7'h0, first_led_ramp_on}, {7'h0, shadow[a][5]});
			end
			rd(a);
			chk(rd_val, shadow[a]);
		end
		// All ones: reserved bits must drop, both settings high
		wr(8'h47, 8'hff);
		rd(8'h47);
		chk(rd_val, 8'h2f);
		chk({3'h0, first_led_ramp_on, first_led_sink_level}, 8'h1f);
		// Sequencer: four phases of 2,3,1,2 ticks inside a 12 tick period
		wr(8'h48, 8'h82);
		wr(8'h49, 8'h83);
		wr(8'h4a, 8'h81);
		wr(8'h4b, 8'h82);
		wr(8'h4c, 8'h8c);
		wr(8'h4d, 8'h1f);
		wr(8'h4e, 8'h1f);
		repeat (150) @(posedge clk);
		mon_en = 1'b1;
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			#1 chk({7'h0, first_led_drive_signal}, 8'h01);
		end
		mon_en = 1'b0;
		chk(8'(armed), 8'h01);
		// Duty: the lowest code, then random ones; any whole round of slots sees each once
		for (int k = 0; k < 3; k++) begin
			duty_code = (k == 0) ? 5'h00 : 5'($urandom);
			wr(8'h4d, {3'h0, duty_code});
			repeat (4) @(posedge clk);
			hi_cnt = 0;
			repeat (32 * SLOT) begin
				@(posedge clk);
				#1 hi_cnt += int'(first_led_drive_signal);
			end
			chk(8'(hi_cnt), 8'(duty_cycles(duty_code)));
		end
		// Zero lit time keeps the output dark whatever the duty
		wr(8'h4e, 8'h00);
		repeat (4 * TK) @(posedge clk);
		for (int i = 0; i < 200; i++) begin
			@(posedge clk);
			#1 chk({7'h0, first_led_drive_signal}, 8'h00);
		end
		reset_check();
		print_verdict();
	end
endmodule
